// File: common/rwk_pkg.sv
package rwk_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PM_CONTROL_FIVE = 8'h50;
  localparam logic [7:0] IDX_RESUME_EVENT = 8'h5c;
  localparam logic [7:0] IDX_WAKE_GROUP_RING = 8'h5f;
  localparam logic [7:0] IDX_WAKE_ENABLE_LOW = 8'h6a;
  localparam logic [7:0] IDX_WAKE_CAUSE = 8'h6b;
  localparam logic [7:0] IDX_FEATURE_ONE = 8'ha0;
  localparam logic [7:0] IDX_WAKE_ENABLE_HIGH = 8'hb1;
  localparam logic [7:0] IDX_KEEPER_GROUP = 8'hd4;
  localparam logic [7:0] IDX_SUSPEND_PIN_STATE = 8'hd5;
  localparam logic [7:0] IDX_INT_STATUS = 8'he0;
  localparam logic [7:0] IDX_INT_MASK = 8'he1;
  // field positions
  localparam int PEND_BIT = 1;
  localparam int READY_BIT = 2;
  localparam int EVENT_CLR_BIT = 6;
  localparam int GROUP_EN_BIT = 5;
  localparam int RING_EN_BIT = 4;
  localparam int KEEP_EN_BIT = 6;
  localparam int CAUSE_RING = 0;
  localparam int CAUSE_GROUP = 1;
  localparam int CAUSE_PIN = 2;
  localparam int FLOAT_ERROR_PIN_DIS_BIT = 5;
  // two-bit keeper and select modes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h2;
  localparam logic [1:0] DACK_LOW = 2'h0;
  localparam logic [1:0] DACK_TRI = 2'h1;
  localparam logic [1:0] DACK_PATTERN = 2'h2;
  localparam logic [2:0] DACK_PATTERN_VALUE = 3'h4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // timing: ring input sampled near 32 kHz
  localparam int CLK_HZ = 20000000;
  localparam int RING_SAMPLE_HZ = 32768;
  localparam int RING_DIV = CLK_HZ / RING_SAMPLE_HZ;

  // software-visible configuration bytes
  typedef struct packed {
    logic [7:0] group_ring;
    logic [7:0] wake_low;
    logic [7:0] wake_high;
    logic [7:0] feature_one;
    logic [7:0] keeper_group;
    logic [7:0] pin_state;
    logic [2:0] int_mask;
  } rwk_cfg_type;

  // pad controls driven toward the cpu bus pads
  typedef struct packed {
    logic addr_keep;
    logic data_keep;
    logic ctrl_keep;
    logic float_error_pin_pullup;
    logic float_error_pin_pulldown;
    logic [2:0] dack_out;
    logic [2:0] dack_oe;
    logic [2:0] dack_pulldown;
  } rwk_pads_type;
endpackage : rwk_pkg

// File: rtl/rwk_top.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - two wake-enable bytes, one bit per source
// - read-only cause byte: pin, group, ring
// - group cause set: enable reads show latched
// - latched sources held until event cleared
// - pending bit reads event still active
// - auto keepers only in hold or suspend
// - keepers on address, data, control; pull low
// - auto keeper feature needs enable bit
// - per-group mode: auto, on, off, reserved
// - float error pull-up active, pull-down suspend
// - dma ack lines follow suspend setting
// - group wakes only with global enable
// - ring transitions above count raise event
// - rising edges wake, irq8 falling edge
// - suspend pin always wakes, raises event
module rwk_top #(
  parameter logic [2:0] DACK_KEEPER_MASK = 3'h1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] irq_lines,
  input wire logic [3:0] external_power_input,
  input wire logic ring_indicate_input,
  input wire logic suspend_resume_pin,
  input wire logic suspend_active,
  input wire logic bus_hold,
  input wire logic [2:0] dma_ack_normal,
  output logic resume_power_event,
  output logic keeper_addr_en,
  output logic keeper_data_en,
  output logic keeper_ctrl_en,
  output logic float_error_pullup_en,
  output logic float_error_pulldown_en,
  output logic [2:0] dma_ack_select_lines_out,
  output logic [2:0] dma_ack_select_lines_oe,
  output logic [2:0] dma_ack_select_lines_pulldown,
  output logic irq_out
);

  // whole module state
  typedef struct packed {
    rwk_pkg::rwk_cfg_type cfg;
    rwk_pkg::rwk_pads_type pads;
    logic [15:0] src_prev;    // last sample of wake sources
    logic [15:0] latched;     // enabled sources that fired
    logic [2:0] cause;        // resume cause bits
    logic pending;            // resume event active
    logic [2:0] int_status;   // sticky interrupt bits
    logic irq;
    logic [3:0] ring_cnt;     // saturating transition count
    logic ring_prev;
    logic [9:0] div_cnt;      // 32 kHz sample divider
    logic pin_prev;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } rwk_state_type;

  rwk_state_type state;
  rwk_state_type next_state;

  // sources in register bit order: high byte, low byte
  // irq 0, 2, 6 and 13 have no enable bit and never wake
  logic [15:0] sources;
  assign sources = {external_power_input[3], external_power_input[2],
    irq_lines[15], irq_lines[14], irq_lines[12], irq_lines[11],
    irq_lines[10], irq_lines[9],
    external_power_input[1], external_power_input[0],
    irq_lines[8], irq_lines[7], irq_lines[5], irq_lines[4],
    irq_lines[3], irq_lines[1]};

  // address match on a word-aligned register index
  function automatic logic rwk_hit(input logic [11:0] addr,
                                   input logic [7:0] idx);
    // a misaligned address never matches, so it reads as unmapped
    rwk_hit = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction : rwk_hit

  // keeper engage decision for one group
  function automatic logic rwk_keep(input logic [1:0] mode,
                                    input logic auto_on);
    unique case (mode)
      rwk_pkg::MODE_AUTO: rwk_keep = auto_on;
      rwk_pkg::MODE_ON: rwk_keep = 1'b1;
      rwk_pkg::MODE_OFF: rwk_keep = 1'b0;
      default: rwk_keep = 1'b0; // reserved code held off, safest
    endcase
  endfunction : rwk_keep

  // next-state logic
  always_comb begin
    logic access;
    logic wr;
    logic rd_hit;
    logic [15:0] edges;
    logic [15:0] wake_en;
    logic [15:0] fired;
    logic [2:0] new_cause;
    logic tick;
    logic ring_edge;
    logic clear_event;
    logic auto_on;
    logic [7:0] rbyte;
    access = 1'b0;
    wr = 1'b0;
    rd_hit = 1'b0;
    edges = 16'h0000;
    wake_en = 16'h0000;
    fired = 16'h0000;
    new_cause = 3'h0;
    tick = 1'b0;
    ring_edge = 1'b0;
    clear_event = 1'b0;
    auto_on = 1'b0;
    rbyte = 8'h00;
    next_state = state;

    // apb: one wait state, then answer
    // access is the second access cycle; writes land only there
    access = psel && penable && state.ready;
    next_state.ready = psel && penable && !state.ready;
    wr = access && pwrite && pstrb[0];

    // wake edges, irq8 is active on its falling edge
    // edges are taken against the previous cycle, with no filter
    edges = sources & ~state.src_prev;
    edges[5] = state.src_prev[5] & ~sources[5];
    next_state.src_prev = sources;
    wake_en = {state.cfg.wake_high, state.cfg.wake_low};
    // outside suspend a moving line is only tracked, never latched
    fired = suspend_active ? (edges & wake_en) : 16'h0000;
    // group only resumes when globally enabled
    if (state.cfg.group_ring[rwk_pkg::GROUP_EN_BIT]) begin
      new_cause[rwk_pkg::CAUSE_GROUP] = |fired;
    end

    // suspend pin asserts low, always a wake source
    new_cause[rwk_pkg::CAUSE_PIN] = suspend_active && state.pin_prev &&
      !suspend_resume_pin;
    next_state.pin_prev = suspend_resume_pin;
    // pin_prev resets high so a released reset is no false fall

    // ring sampling on the divided tick
    // the divider free-runs; tick phase is of no matter to a slow line
    tick = (state.div_cnt == 10'(rwk_pkg::RING_DIV - 1));
    next_state.div_cnt = tick ? 10'h000 : state.div_cnt + 10'h001;
    if (tick) begin
      next_state.ring_prev = ring_indicate_input;
      ring_edge = ring_indicate_input != state.ring_prev;
    end
    if (ring_edge && suspend_active && state.ring_cnt != 4'hf) begin
      next_state.ring_cnt = state.ring_cnt + 4'h1;
    end
    // event on each counted transition that leaves the count above the setting;
    // a level test would raise the event again in its clear cycle
    // a setting of 15 can never be exceeded by the saturating count
    if (state.cfg.group_ring[rwk_pkg::RING_EN_BIT] &&
        next_state.ring_cnt != state.ring_cnt &&
        next_state.ring_cnt > state.cfg.group_ring[3:0]) begin
      new_cause[rwk_pkg::CAUSE_RING] = 1'b1;
    end

    // event clear by write of one; new events win over it
    clear_event = wr && rwk_hit(paddr, rwk_pkg::IDX_RESUME_EVENT) &&
      pwdata[rwk_pkg::EVENT_CLR_BIT];
    // the ring count restarts too, so a later call counts afresh
    if (clear_event) begin
      next_state.latched = 16'h0000;
      next_state.cause = 3'h0;
      next_state.pending = 1'b0;
      next_state.ring_cnt = 4'h0;
    end
    // group latch only when the group itself counts
    if (new_cause[rwk_pkg::CAUSE_GROUP]) begin
      next_state.latched = next_state.latched | fired;
    end
    next_state.cause = next_state.cause | new_cause;
    if (|new_cause) begin
      next_state.pending = 1'b1;
    end

    // interrupt status: clear by one, set wins
    // a cause in the clearing cycle keeps its status bit set
    if (wr && rwk_hit(paddr, rwk_pkg::IDX_INT_STATUS)) begin
      next_state.int_status = state.int_status & ~pwdata[2:0];
    end
    next_state.int_status = next_state.int_status | new_cause;
    next_state.irq = |(next_state.int_status & state.cfg.int_mask);

    // register writes
    // only the low byte holds fields; pstrb[0] gates every write
    // the cause and pm control five bytes are read-only here
    if (wr) begin
      if (rwk_hit(paddr, rwk_pkg::IDX_WAKE_GROUP_RING)) begin
        next_state.cfg.group_ring = pwdata[7:0];
      end
      if (rwk_hit(paddr, rwk_pkg::IDX_WAKE_ENABLE_LOW)) begin
        next_state.cfg.wake_low = pwdata[7:0];
      end
      if (rwk_hit(paddr, rwk_pkg::IDX_WAKE_ENABLE_HIGH)) begin
        next_state.cfg.wake_high = pwdata[7:0];
      end
      if (rwk_hit(paddr, rwk_pkg::IDX_FEATURE_ONE)) begin
        next_state.cfg.feature_one = pwdata[7:0];
      end
      if (rwk_hit(paddr, rwk_pkg::IDX_KEEPER_GROUP)) begin
        next_state.cfg.keeper_group = pwdata[7:0];
      end
      if (rwk_hit(paddr, rwk_pkg::IDX_SUSPEND_PIN_STATE)) begin
        next_state.cfg.pin_state = pwdata[7:0];
      end
      if (rwk_hit(paddr, rwk_pkg::IDX_INT_MASK)) begin
        next_state.cfg.int_mask = pwdata[2:0];
      end
    end

    // read mux; enable bytes switch to latched view
    // reads have no side effects; the byte is registered into rdata
    // unmapped writes match no branch above and are dropped
    rd_hit = 1'b1;
    if (rwk_hit(paddr, rwk_pkg::IDX_PM_CONTROL_FIVE)) begin
      rbyte[rwk_pkg::PEND_BIT] = state.pending;
      rbyte[rwk_pkg::READY_BIT] = state.pending && suspend_active;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_RESUME_EVENT)) begin
      // the clear bit reads back as the pending event
      rbyte[rwk_pkg::EVENT_CLR_BIT] = state.pending;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_WAKE_GROUP_RING)) begin
      rbyte = state.cfg.group_ring;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_WAKE_ENABLE_LOW)) begin
      rbyte = state.cause[rwk_pkg::CAUSE_GROUP] ? state.latched[7:0] :
        state.cfg.wake_low;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_WAKE_CAUSE)) begin
      rbyte = {5'h00, state.cause};
    end else if (rwk_hit(paddr, rwk_pkg::IDX_FEATURE_ONE)) begin
      rbyte = state.cfg.feature_one;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_WAKE_ENABLE_HIGH)) begin
      rbyte = state.cause[rwk_pkg::CAUSE_GROUP] ? state.latched[15:8] :
        state.cfg.wake_high;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_KEEPER_GROUP)) begin
      rbyte = state.cfg.keeper_group;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_SUSPEND_PIN_STATE)) begin
      rbyte = state.cfg.pin_state;
    end else if (rwk_hit(paddr, rwk_pkg::IDX_INT_STATUS)) begin
      rbyte = {5'h00, state.int_status};
    end else if (rwk_hit(paddr, rwk_pkg::IDX_INT_MASK)) begin
      rbyte = {5'h00, state.cfg.int_mask};
    end else begin
      rd_hit = 1'b0; // unmapped: error, reads zero
    end
    next_state.rdata = 32'h00000000;
    next_state.err = 1'b0;
    if (psel && penable && !state.ready) begin
      next_state.rdata = pwrite ? 32'h00000000 : {24'h000000, rbyte};
      next_state.err = !rd_hit;
    end

    // keepers: auto only with feature on, in hold or suspend
    // forced modes 01 and 10 ignore the feature bit on purpose
    // forced on may cost less than auto when the bus floats for long
    auto_on = state.cfg.feature_one[rwk_pkg::KEEP_EN_BIT] &&
      (bus_hold || suspend_active);
    next_state.pads.addr_keep =
      rwk_keep(state.cfg.keeper_group[7:6], auto_on);
    next_state.pads.data_keep =
      rwk_keep(state.cfg.keeper_group[5:4], auto_on);
    next_state.pads.ctrl_keep =
      rwk_keep(state.cfg.keeper_group[3:2], auto_on);

    // float error pin pulls follow the keeper feature
    // only the pull-up has a disable bit; the pull-down has none
    next_state.pads.float_error_pin_pullup =
      state.cfg.feature_one[rwk_pkg::KEEP_EN_BIT] && !suspend_active &&
      !state.cfg.pin_state[rwk_pkg::FLOAT_ERROR_PIN_DIS_BIT];
    next_state.pads.float_error_pin_pulldown =
      state.cfg.feature_one[rwk_pkg::KEEP_EN_BIT] &&
      suspend_active;

    // dma ack lines: normal function unless suspended
    // DACK_KEEPER_MASK lists the lines that own a pull-down
    next_state.pads.dack_out = dma_ack_normal;
    next_state.pads.dack_oe = 3'h7;
    next_state.pads.dack_pulldown = 3'h0;
    if (suspend_active) begin
      unique case (state.cfg.pin_state[7:6])
        rwk_pkg::DACK_LOW: begin
          next_state.pads.dack_out = 3'h0;
          next_state.pads.dack_oe = ~DACK_KEEPER_MASK;
          next_state.pads.dack_pulldown = DACK_KEEPER_MASK;
        end
        rwk_pkg::DACK_TRI: begin
          next_state.pads.dack_oe = 3'h0;
        end
        rwk_pkg::DACK_PATTERN: begin
          next_state.pads.dack_out = rwk_pkg::DACK_PATTERN_VALUE;
        end
        default: begin
          // reserved code floats the lines rather than guess
          next_state.pads.dack_oe = 3'h0;
        end
      endcase
    end
  end

  // state register; every field a constant at reset
  // src_prev resets low while irq8 idles high; only its fall counts,
  // and a rising edge seen at release only counts in suspend
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.pin_prev <= 1'b1;
      state.pads.dack_oe <= 3'h7;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  // pad controls lag their inputs by one clock through these flops
  assign prdata = state.rdata;
  assign pready = state.ready;
  // err is set in the same cycle as ready, so the flop stands alone
  assign pslverr = state.err;
  assign resume_power_event = state.pending;
  assign keeper_addr_en = state.pads.addr_keep;
  assign keeper_data_en = state.pads.data_keep;
  assign keeper_ctrl_en = state.pads.ctrl_keep;
  assign float_error_pullup_en = state.pads.float_error_pin_pullup;
  assign float_error_pulldown_en = state.pads.float_error_pin_pulldown;
  assign dma_ack_select_lines_out = state.pads.dack_out;
  assign dma_ack_select_lines_oe = state.pads.dack_oe;
  assign dma_ack_select_lines_pulldown = state.pads.dack_pulldown;
  assign irq_out = state.irq;

endmodule : rwk_top

// File: tb/rwk_top_props.sv
`timescale 1ns/1ps
// port-side watcher for the wake and keeper block
module rwk_top_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic suspend_active,
  input wire logic suspend_resume_pin,
  input wire logic resume_power_event,
  input wire logic float_error_pullup_en,
  input wire logic float_error_pulldown_en,
  input wire logic [2:0] dma_ack_select_lines_oe,
  input wire logic [2:0] dma_ack_select_lines_pulldown
);
  // byte address of the event clear register
  localparam logic [11:0] EV_ADDR = {2'h0, rwk_pkg::IDX_RESUME_EVENT, 2'h0};
  logic clr_wr; // completed write of a one to the clear bit
  assign clr_wr = psel && penable && pready && pwrite && paddr == EV_ADDR
    && pstrb[0] && pwdata[6];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_one_wait: assert property (
    $rose(penable) && psel |-> !pready ##1 pready ##1 !pready)
    else $error("apb answer not after one wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_event_held: assert property (
    resume_power_event && !clr_wr |=> resume_power_event)
    else $error("resume event dropped without clear");
  a_pin_wakes: assert property (
    suspend_active && $past(suspend_active) && $fell(suspend_resume_pin)
    |-> ##[1:4] resume_power_event)
    else $error("suspend pin fall did not raise event");
  a_float_error_pin_excl: assert property (
    !(float_error_pullup_en && float_error_pulldown_en))
    else $error("float error pulled both ways");
  a_float_error_pin_down: assert property (
    float_error_pulldown_en |-> $past(suspend_active))
    else $error("float error pull-down outside suspend");
  a_float_error_pin_up: assert property (
    float_error_pullup_en |-> !$past(suspend_active))
    else $error("float error pull-up in suspend");
  a_dack_fight: assert property (
    (dma_ack_select_lines_oe & dma_ack_select_lines_pulldown) == 3'h0)
    else $error("dma ack line driven and pulled");
endmodule : rwk_top_props

bind rwk_top rwk_top_props u_props (.clk, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .suspend_active, .suspend_resume_pin, .resume_power_event,
  .float_error_pullup_en, .float_error_pulldown_en,
  .dma_ack_select_lines_oe, .dma_ack_select_lines_pulldown);

// File: tb/rwk_far_side.sv
`timescale 1ns/1ps
// far side: interrupt lines, ring, suspend pin and cpu bus state
module rwk_far_side (
  input wire logic clk,
  output logic [15:0] irq_lines,
  output logic [3:0] external_power_input,
  output logic ring_indicate_input,
  output logic suspend_resume_pin,
  output logic suspend_active,
  output logic bus_hold,
  output logic [2:0] dma_ack_normal
);
  // idle levels; irq8 rests high so its wake edge is the fall
  initial begin
    irq_lines = 16'h0100;
    external_power_input = 4'h0;
    ring_indicate_input = 1'b0;
    suspend_resume_pin = 1'b1;
    suspend_active = 1'b0;
    bus_hold = 1'b0;
    dma_ack_normal = 3'h5;
  end
  // flip a line and back; 16 is the suspend pin, 17 to 20 power inputs
  task pulse(input int n);
    @(posedge clk);
    if (n == 16) suspend_resume_pin <= 1'b0;
    else if (n > 16) external_power_input[n - 17] <= 1'b1;
    else irq_lines[n] <= ~irq_lines[n];
    repeat (3) @(posedge clk);
    if (n == 16) suspend_resume_pin <= 1'b1;
    else if (n > 16) external_power_input[n - 17] <= 1'b0;
    else irq_lines[n] <= ~irq_lines[n];
  endtask : pulse
  // suspend and hold state of the system
  task state(input logic s, input logic h);
    @(posedge clk);
    suspend_active <= s;
    bus_hold <= h;
  endtask : state
  // one ring transition, held long past the sample period
  task ring;
    @(posedge clk);
    ring_indicate_input <= ~ring_indicate_input;
  endtask : ring
endmodule : rwk_far_side

// File: tb/tb_top.sv
`timescale 1ns/1ps
// register-level test of the wake and keeper block
module tb_top;
  localparam logic [7:0] LO = rwk_pkg::IDX_WAKE_ENABLE_LOW;
  localparam logic [7:0] HI = rwk_pkg::IDX_WAKE_ENABLE_HIGH;
  localparam logic [7:0] CS = rwk_pkg::IDX_WAKE_CAUSE;
  localparam logic [7:0] EV = rwk_pkg::IDX_RESUME_EVENT;
  localparam logic [7:0] GR = rwk_pkg::IDX_WAKE_GROUP_RING;
  localparam logic [7:0] PM = rwk_pkg::IDX_PM_CONTROL_FIVE;
  localparam logic [7:0] FE = rwk_pkg::IDX_FEATURE_ONE;
  localparam logic [7:0] PS = rwk_pkg::IDX_SUSPEND_PIN_STATE;
  localparam logic [7:0] IS = rwk_pkg::IDX_INT_STATUS;
  localparam logic [7:0] IM = rwk_pkg::IDX_INT_MASK;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, resume_power_event, irq_out, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic keeper_addr_en, keeper_data_en, keeper_ctrl_en;
  logic float_error_pullup_en, float_error_pulldown_en;
  logic [15:0] irq_lines;
  logic [3:0] external_power_input;
  logic ring_indicate_input, suspend_resume_pin, suspend_active, bus_hold;
  logic [2:0] dma_ack_normal, dma_ack_select_lines_out;
  logic [2:0] dma_ack_select_lines_oe, dma_ack_select_lines_pulldown;
  logic [5:0] dack_exp [3] = '{6'h0e, 6'h00, 6'h07}; // pulldown, oe
  int bad_count = 0, check_count = 0;
  wire logic [2:0] keep = {keeper_addr_en, keeper_data_en, keeper_ctrl_en};
  wire logic [1:0] float_error_pin = {float_error_pullup_en, float_error_pulldown_en};
  rwk_top u_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .irq_lines, .external_power_input,
    .ring_indicate_input, .suspend_resume_pin, .suspend_active, .bus_hold,
    .dma_ack_normal, .resume_power_event, .keeper_addr_en, .keeper_data_en,
    .keeper_ctrl_en, .float_error_pullup_en, .float_error_pulldown_en,
    .dma_ack_select_lines_out, .dma_ack_select_lines_oe,
    .dma_ack_select_lines_pulldown, .irq_out);
  rwk_far_side u_far (.clk, .irq_lines, .external_power_input,
    .ring_indicate_input, .suspend_resume_pin, .suspend_active, .bus_hold,
    .dma_ack_normal);
  initial begin
    forever #25 clk = ~clk;
  end
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  // one apb transfer; waits for ready, the watchdog bounds a hang
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pstrb} <= {1'b1, w, 2'h0, idx, 2'h0, 4'hf};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task rchk(input logic [7:0] idx, input logic [7:0] exp, input string s);
    apb(1'b0, idx, 8'h0);
    chk(s, rd, {24'h0, exp});
  endtask : rchk
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // hang guard, well above the ring waits
  initial begin
    idle(20000);
    bad_count++;
    give_verdict;
  end
  initial begin
    idle(3);
    reset_n <= 1'b1;
    rchk(LO, 8'h00, "low rst");
    rchk(HI, 8'h00, "high rst");
    rchk(GR, 8'h00, "group rst");
    wr(LO, 8'h26);
    wr(HI, 8'h40);
    rchk(LO, 8'h26, "low");
    rchk(HI, 8'h40, "high");
    apb(1'b0, 8'h01, 8'h00);
    chk("unmapped", 32'(er), 32'h1);
    $display("register test done");
    // group disabled first, then enabled; irq5 is not enabled
    u_far.state(1'b1, 1'b0);
    u_far.pulse(3);
    idle(4);
    rchk(CS, 8'h00, "cause off");
    wr(GR, 8'h20);
    u_far.pulse(3);
    u_far.pulse(8);
    u_far.pulse(5);
    u_far.pulse(19);
    idle(4);
    chk("event", 32'(resume_power_event), 32'h1);
    rchk(CS, 8'h02, "cause group");
    rchk(LO, 8'h22, "latched low");
    rchk(HI, 8'h40, "latched high");
    rchk(PM, 8'h06, "pending");
    wr(EV, 8'h40);
    rchk(CS, 8'h00, "cause cleared");
    rchk(LO, 8'h26, "enables back");
    rchk(PM, 8'h00, "not pending");
    // sticky status; a mask bit of one lets its status through
    rchk(IS, 8'h02, "status");
    wr(IM, 8'h05);
    idle(2);
    chk("irq masked", 32'(irq_out), 32'h0);
    wr(IM, 8'h02);
    idle(2);
    chk("irq open", 32'(irq_out), 32'h1);
    wr(IS, 8'h02);
    idle(2);
    chk("irq cleared", 32'(irq_out), 32'h0);
    $display("wake test done");
    u_far.pulse(16);
    idle(4);
    rchk(CS, 8'h04, "cause pin");
    wr(EV, 8'h40);
    wr(IS, 8'h07);
    // count of one needs a second transition
    wr(GR, 8'h11);
    u_far.ring;
    idle(1300);
    rchk(CS, 8'h00, "ring once");
    u_far.ring;
    idle(1300);
    rchk(CS, 8'h01, "ring twice");
    wr(EV, 8'h40);
    $display("ring test done");
    u_far.state(1'b0, 1'b0);
    wr(FE, 8'h40);
    idle(3);
    chk("keep active", 32'(keep), 32'h0);
    u_far.state(1'b0, 1'b1);
    idle(3);
    chk("keep hold", 32'(keep), 32'h7);
    wr(FE, 8'h00);
    idle(3);
    chk("keep off", 32'(keep), 32'h0);
    wr(rwk_pkg::IDX_KEEPER_GROUP, 8'h18);
    idle(3);
    chk("keep forced", 32'(keep), 32'h2);
    wr(FE, 8'h40);
    u_far.state(1'b1, 1'b0);
    idle(3);
    chk("keep suspend", 32'(keep), 32'h6);
    chk("float_error_pin suspend", 32'(float_error_pin), 32'h1);
    u_far.state(1'b0, 1'b0);
    idle(3);
    chk("float_error_pin active", 32'(float_error_pin), 32'h2);
    wr(PS, 8'h20);
    idle(3);
    chk("float_error_pin no pullup", 32'(float_error_pin), 32'h0);
    $display("keeper test done");
    u_far.state(1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(PS, {2'(i), 6'h00});
      idle(3);
      chk("dack", 32'({dma_ack_select_lines_pulldown,
        dma_ack_select_lines_oe}), 32'(dack_exp[i]));
    end
    chk("dack pattern", 32'(dma_ack_select_lines_out), 32'h4);
    $display("dack test done");
    give_verdict;
  end
endmodule : tb_top
